// >>> verilog/aluc_ctrl.sv
// amplifier level update control: gain code registers and their sources
`timescale 1ns/1ps
module aluc_ctrl
  import aluc_pkg::*;
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // configuration straps
  input wire logic mode_strap,
  input wire logic config_strap,
  // serial control port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // parallel level port
  input wire logic [5:0] parallel_level_port,
  // transmit nibble port, on the interface clock
  input wire logic interface_clock,
  input wire logic gain_strobe,
  input wire logic tx_word_sync,
  input wire logic [5:0] tx_nibble,
  // towards the interpolation filter
  output logic [5:0] filter_nibble,
  output logic filter_valid,
  output logic filter_word_sync,
  // amplifier controls
  output aluc_stage_t receive_amplifier,
  output logic [3:0] converter_atten,
  output logic [5:0] driver_atten,
  output logic driver_enable
);

  aluc_core_t q;
  aluc_core_t d;
  aluc_link_t lq;
  aluc_link_t ld;
  aluc_txp_t negcap;
  aluc_txp_t smp;
  logic [15:0] nsh;
  logic sclk_rise;
  logic sclk_fall;
  logic wr_stb;
  logic hs;
  logic rx_ser_go;
  logic tx_ser_go;
  logic [5:0] rx_par_code;
  logic strobe;
  logic load;

  // split of the receive code over the three stages
  function automatic aluc_stage_t lut(input logic [5:0] c);
    logic [5:0] g;
    logic [5:0] r;
    aluc_stage_t s;
    g = (c > CODE_MAX) ? CODE_MAX : c;
    s.coarse = 2'(g / ST1_DB);
    r = 6'(g - 6'(s.coarse * ST1_DB));
    s.mid = 2'(r / ST2_DB);
    s.fine = 3'(r % ST2_DB);
    return s;
  endfunction

  // 3-bit level to 6-bit receive code, 8 dB per step
  function automatic logic [5:0] map3(input logic [2:0] c);
    logic [2:0] m;
    m = 3'(c - 3'h1);
    return (c <= 3'h1) ? RX_RST : {m, 3'h0};
  endfunction

  // readback; gain codes read as zero unless their enable is set
  function automatic logic [7:0] rd_data(input logic [6:0] a, input aluc_core_t s);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_RX) begin
      v = {1'b0, s.rx_en, s.rx_en ? s.rx_code : 6'h00};
    end else if (a == ADDR_TX) begin
      v = {1'b0, s.tx_en, s.tx_en ? s.tx_code : 6'h00};
    end else if (a == ADDR_SRC) begin
      v = s.src;
    end else if (a == ADDR_OUT) begin
      v = s.outc;
    end else if (a == ADDR_CLK) begin
      v = s.clkc;
    end
    return v;
  endfunction

  assign sclk_rise = q.sync.sclk & ~q.sclk_p;
  assign sclk_fall = ~q.sync.sclk & q.sclk_p;
  assign nsh = {q.shreg[14:0], q.sync.sdi};
  assign wr_stb = sclk_rise & ~q.sync.csn & (q.bitcnt == DATA_LAST) & ~q.rd;
  // a nibble-port load waits in the handshake until taken here
  assign hs = q.req_s != q.ack;
  assign rx_par_code = (q.src[B_MAP3] & ~q.fd) ? map3(q.sync.level[5:3]) : q.sync.level;
  // lower-priority serial update holds off while a faster source owns the register
  assign rx_ser_go = q.pend_rx & (q.rate_cnt == 7'h00) & ~hs & ~q.src[B_SEL_RX];
  assign tx_ser_go = q.pend_tx & (q.rate_cnt == 7'h00) & ~q.src[B_SEL_TX] & ~rx_ser_go;

  always_comb begin
    d = q;
    d.meta = {spi_sclk, spi_cs_n, spi_sdi, mode_strap, config_strap, parallel_level_port};
    d.sync = q.meta;
    d.sclk_p = q.sync.sclk;
    d.req_m = lq.req;
    d.req_s = q.req_m;
    d.fd = q.sync.mode;
    // serial shifter
    if (q.sync.csn) begin
      d.bitcnt = 4'h0;
      d.rd = 1'b0;
      d.sdo_oe = 1'b0;
    end else if (sclk_rise) begin
      d.shreg = nsh;
      d.bitcnt = 4'(q.bitcnt + 4'h1);
      if (q.bitcnt == ADDR_LAST) begin
        d.rd = nsh[7];
        d.shout = rd_data(nsh[6:0], q);
      end
    end else if (sclk_fall && q.rd && q.bitcnt > ADDR_LAST) begin
      d.sdo = q.shout[7];
      d.shout = {q.shout[6:0], 1'b0};
      d.sdo_oe = 1'b1;
    end
    if (q.rate_cnt != 7'h00) begin
      d.rate_cnt = 7'(q.rate_cnt - 7'h01);
    end
    // serial gain updates share one rate slot
    if (rx_ser_go) begin
      d.rx_code = q.prx;
      d.pend_rx = 1'b0;
      d.rate_cnt = RATE_LOAD;
    end
    if (tx_ser_go) begin
      d.tx_code = q.ptx;
      d.pend_tx = 1'b0;
      d.rate_cnt = RATE_LOAD;
    end
    // writes come after the apply so a new write is never lost
    if (wr_stb) begin
      if (nsh[14:8] == ADDR_RX) begin
        d.rx_en = nsh[B_UPD_EN];
        if (nsh[B_UPD_EN]) begin
          d.pend_rx = 1'b1;
          d.prx = nsh[5:0];
        end
      end else if (nsh[14:8] == ADDR_TX) begin
        d.tx_en = nsh[B_UPD_EN];
        if (nsh[B_UPD_EN]) begin
          d.pend_tx = 1'b1;
          d.ptx = nsh[5:0];
        end
      end else if (nsh[14:8] == ADDR_SRC) begin
        d.src = nsh[7:0];
      end else if (nsh[14:8] == ADDR_OUT) begin
        d.outc = nsh[7:0];
      end else if (nsh[14:8] == ADDR_CLK) begin
        d.clkc = nsh[7:0];
      end
    end
    // parallel level port, no qualifier; each select loads only its own register
    if (q.src[B_SEL_RX]) begin
      d.rx_code = rx_par_code;
    end
    if (q.src[B_SEL_TX]) begin
      d.tx_code = q.sync.level;
    end
    // nibble port load has the last word
    if (hs) begin
      d.ack = ~q.ack;
      d.rx_code = lq.data;
    end
    // straps settle through the synchroniser before defaults are taken
    if (!q.strap_done) begin
      if (q.strap_cnt == STRAP_WAIT) begin
        d.strap_done = 1'b1;
        d.src[B_TXPORT] = q.sync.mode;
        d.src[B_SEL_RX] = ~q.sync.mode;
        d.src[B_MAP3] = ~q.sync.mode & q.sync.cfg;
      end else begin
        d.strap_cnt = 2'(q.strap_cnt + 2'h1);
      end
    end
    d.stage = lut(d.rx_code);
    d.drv_en = ~d.outc[B_DIRECT];
    d.conv = d.outc[B_DIRECT] ? d.tx_code[3:0] : 4'h0;
    d.drv = d.outc[B_DIRECT] ? 6'h00 : ((d.tx_code > DRV_MAX) ? DRV_MAX : d.tx_code);
    if (!rst_n) begin
      d = '0;
      // select idles high so no phantom frame starts right after reset
      d.meta.csn = 1'b1;
      d.sync.csn = 1'b1;
      d.rx_code = RX_RST;
      d.tx_code = TX_RST;
      d.src = REG_RST;
      d.outc = REG_RST;
      d.clkc = REG_RST;
      d.stage = lut(RX_RST);
      d.drv_en = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign spi_sdo = q.sdo;
  assign spi_sdo_oe = q.sdo_oe;
  assign receive_amplifier = q.stage;
  assign converter_atten = q.conv;
  assign driver_atten = q.drv;
  assign driver_enable = q.drv_en;

  // link side: falling-edge copy for the inverted sampling edge
  always_ff @(negedge interface_clock) begin
    negcap <= {gain_strobe, tx_word_sync, tx_nibble};
  end

  // inverted mode costs half a link clock of latency
  assign smp = lq.cfg_s.inv ? negcap : {gain_strobe, tx_word_sync, tx_nibble};
  assign strobe = smp.gain | lq.cfg_s.sw;
  // one sampled cycle of strobe high, sync low is enough for a load
  assign load = lq.cfg_s.fd & lq.cfg_s.txen & strobe & ~smp.sync;

  always_comb begin
    ld = lq;
    ld.rst_m = rst_n;
    ld.rst_s = lq.rst_m;
    // config bits change rarely; each bit only needs its own two flops
    ld.cfg_m = {q.fd, q.src[B_TXPORT], q.src[B_SW_STB], q.clkc[B_CLK_INV]};
    ld.cfg_s = lq.cfg_m;
    ld.ack_m = q.ack;
    ld.ack_s = lq.ack_m;
    // a load arriving while the last is in flight is dropped
    if (load && lq.req == lq.ack_s) begin
      ld.data = smp.nib;
      ld.req = ~lq.req;
    end
    ld.fvalid = lq.cfg_s.fd & ~strobe;
    ld.fnib = smp.nib;
    ld.fsync = smp.sync;
    if (!lq.rst_s) begin
      ld = '0;
      ld.rst_m = rst_n;
      ld.rst_s = lq.rst_m;
    end
  end

  always_ff @(posedge interface_clock) begin
    lq <= ld;
  end

  assign filter_nibble = lq.fnib;
  assign filter_valid = lq.fvalid;
  assign filter_word_sync = lq.fsync;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_rx_reset_min: assert property (rst_n && !$past(rst_n) |-> q.rx_code == RX_RST)
    else $error("receive gain not minimum after reset");

  chk_tx_reset_min: assert property (
    rst_n && !$past(rst_n) |-> q.tx_code == TX_RST && !q.src[B_SEL_TX])
    else $error("transmit register not at reset state");

  chk_ser_gate: assert property (
    wr_stb && nsh[14:8] == ADDR_RX && !nsh[B_UPD_EN] && !q.pend_rx
    && !q.src[B_SEL_RX] && !hs |=> $stable(q.rx_code))
    else $error("serial write without enable changed receive gain");

  chk_par_rx: assert property (
    q.src[B_SEL_RX] && !q.src[B_MAP3] && !hs |=> q.rx_code == $past(q.sync.level))
    else $error("parallel port not loaded into receive gain");

  chk_par_tx: assert property (
    q.src[B_SEL_TX] |=> q.tx_code == $past(q.sync.level))
    else $error("parallel port not loaded into transmit code");

  chk_map_three: assert property (
    q.src[B_SEL_RX] && q.src[B_MAP3] && !q.fd && !hs
    |=> q.rx_code == map3($past(q.sync.level[5:3])))
    else $error("3-bit mapping wrong");

  chk_rate_gap: assert property (
    rx_ser_go || tx_ser_go |=> q.rate_cnt == RATE_LOAD ##1 !(rx_ser_go || tx_ser_go) [*8])
    else $error("serial updates too close together");

  chk_port_prio: assert property (hs |=> q.rx_code == $past(lq.data))
    else $error("nibble port load lost priority");

  chk_conv_four: assert property (
    q.outc[B_DIRECT] |-> converter_atten == q.tx_code[3:0] && !driver_enable)
    else $error("direct converter mode uses wrong bits");

  chk_lut_sum: assert property (
    6'(q.stage.coarse * ST1_DB) + 6'(q.stage.mid * ST2_DB) + 6'(q.stage.fine)
    == ((q.rx_code > CODE_MAX) ? CODE_MAX : q.rx_code))
    else $error("stage split does not add up");

  chk_filter_route: assert property (@(posedge interface_clock) disable iff (!lq.rst_s)
    lq.cfg_s.fd && !strobe |=> filter_valid)
    else $error("strobe low but nibble not routed to filter");

  // serial applies land exactly the pending code
  chk_rx_ser_apply: assert property (rx_ser_go |=> q.rx_code == $past(q.prx))
    else $error("serial receive code not applied");
  chk_tx_ser_apply: assert property (tx_ser_go |=> q.tx_code == $past(q.ptx))
    else $error("serial transmit code not applied");

  chk_tx_ser_gate: assert property (
    wr_stb && nsh[14:8] == ADDR_TX && !nsh[B_UPD_EN] && !q.pend_tx
    && !q.src[B_SEL_TX] |=> $stable(q.tx_code))
    else $error("serial write without enable changed transmit code");

  // driver path clamps at 19.5 dB
  chk_drv_clamp: assert property (
    !q.outc[B_DIRECT] |-> converter_atten == 4'h0 && driver_enable
    && driver_atten == ((q.tx_code > DRV_MAX) ? DRV_MAX : q.tx_code))
    else $error("driver path attenuation wrong");

  // defaults follow the straps once they have settled
  chk_strap_dflt: assert property (
    !q.strap_done && q.strap_cnt == STRAP_WAIT
    |=> q.src[B_TXPORT] == q.fd && q.src[B_SEL_RX] == !q.fd
    && q.src[B_MAP3] == (!q.fd && $past(q.sync.cfg)))
    else $error("strap defaults not loaded");

  // link side checks run on the interface clock
  chk_half_nolink: assert property (@(posedge interface_clock) disable iff (!lq.rst_s)
    !lq.cfg_s.fd |=> lq.req == $past(lq.req))
    else $error("nibble port load outside full duplex");

  chk_link_load: assert property (@(posedge interface_clock) disable iff (!lq.rst_s)
    load && lq.req == lq.ack_s |=> lq.req != $past(lq.req) && lq.data == $past(smp.nib))
    else $error("nibble port load not taken");

  chk_sw_strobe: assert property (@(posedge interface_clock) disable iff (!lq.rst_s)
    lq.cfg_s.sw |=> !filter_valid)
    else $error("software strobe let nibbles reach the filter");

  chk_filter_copy: assert property (@(posedge interface_clock) disable iff (!lq.rst_s)
    lq.cfg_s.fd && !strobe |=> filter_nibble == $past(smp.nib))
    else $error("filter nibble not the sampled port value");

endmodule

// >>> include/aluc_pkg.sv
// shared constants and types for the amplifier level update control
package aluc_pkg;
  // serial register offsets
  localparam logic [6:0] ADDR_CLK = 7'h05;
  localparam logic [6:0] ADDR_RX = 7'h09;
  localparam logic [6:0] ADDR_TX = 7'h0a;
  localparam logic [6:0] ADDR_SRC = 7'h0b;
  localparam logic [6:0] ADDR_OUT = 7'h0e;
  // field positions
  localparam int B_UPD_EN = 6;
  localparam int B_SEL_TX = 6;
  localparam int B_SEL_RX = 5;
  localparam int B_SW_STB = 3;
  localparam int B_TXPORT = 2;
  localparam int B_MAP3 = 1;
  localparam int B_DIRECT = 0;
  localparam int B_CLK_INV = 1;
  // values after reset
  localparam logic [5:0] RX_RST = 6'h00;
  localparam logic [5:0] TX_RST = 6'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  // serial frame: r/w bit, 7-bit address, 8-bit data, msb first
  localparam logic [3:0] ADDR_LAST = 4'h7;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // serial gain update spacing
  localparam int CLK_NS = 5;
  localparam int SPI_UPD_NS = 625;
  localparam int SPI_UPD_CYC = (SPI_UPD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] RATE_LOAD = 7'(SPI_UPD_CYC - 1);
  // gain split and mapping
  localparam logic [5:0] CODE_MAX = 6'h3c;
  localparam logic [5:0] ST1_DB = 6'h12;
  localparam logic [5:0] ST2_DB = 6'h06;
  localparam logic [5:0] DRV_MAX = 6'h27;

  typedef struct packed {
    logic sclk;
    logic csn;
    logic sdi;
    logic mode;
    logic cfg;
    logic [5:0] level;
  } aluc_pins_t;

  typedef struct packed {
    logic [1:0] coarse;
    logic [1:0] mid;
    logic [2:0] fine;
  } aluc_stage_t;

  typedef struct packed {
    logic gain;
    logic sync;
    logic [5:0] nib;
  } aluc_txp_t;

  typedef struct packed {
    logic fd;
    logic txen;
    logic sw;
    logic inv;
  } aluc_lcfg_t;

  typedef struct packed {
    aluc_pins_t meta;
    aluc_pins_t sync;
    logic sclk_p;
    logic [3:0] bitcnt;
    logic [15:0] shreg;
    logic [7:0] shout;
    logic rd;
    logic sdo;
    logic sdo_oe;
    logic rx_en;
    logic tx_en;
    logic [5:0] rx_code;
    logic [5:0] tx_code;
    logic [7:0] src;
    logic [7:0] outc;
    logic [7:0] clkc;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic fd;
    logic [6:0] rate_cnt;
    logic pend_rx;
    logic pend_tx;
    logic [5:0] prx;
    logic [5:0] ptx;
    logic req_m;
    logic req_s;
    logic ack;
    aluc_stage_t stage;
    logic [3:0] conv;
    logic [5:0] drv;
    logic drv_en;
  } aluc_core_t;

  typedef struct packed {
    logic rst_m;
    logic rst_s;
    aluc_lcfg_t cfg_m;
    aluc_lcfg_t cfg_s;
    logic ack_m;
    logic ack_s;
    logic req;
    logic [5:0] data;
    logic [5:0] fnib;
    logic fvalid;
    logic fsync;
  } aluc_link_t;
endpackage

// >>> sim/aluc_asic.sv
// baseband partner model driving the transmit nibble port
`timescale 1ns/1ps
module aluc_asic
  import aluc_pkg::*;
(
  // link clock
  input wire logic interface_clock,
  // nibble port
  output logic gain_strobe,
  output logic tx_word_sync,
  output logic [5:0] tx_nibble
);
  initial begin
    gain_strobe = 1'b0;
    tx_word_sync = 1'b1;
    tx_nibble = 6'h00;
  end

  // held four link cycles so a load survives the crossing handshake
  task automatic load(input logic [5:0] v, input logic strobe);
    @(posedge interface_clock);
    gain_strobe <= strobe;
    tx_word_sync <= 1'b0;
    tx_nibble <= v;
    repeat (4) @(posedge interface_clock);
    gain_strobe <= 1'b0;
    tx_word_sync <= 1'b1;
    // released data shows the inverse, never the loaded value
    tx_nibble <= ~v;
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the amplifier level update control
`timescale 1ns/1ps
module tb
  import aluc_pkg::*;
;
  logic core_clk, rst_n, mode_strap, config_strap, interface_clock;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [5:0] parallel_level_port, tx_nibble, filter_nibble, driver_atten;
  logic gain_strobe, tx_word_sync, filter_valid, filter_word_sync, driver_enable;
  aluc_stage_t receive_amplifier;
  logic [3:0] converter_atten;
  logic [7:0] rd;
  int fails, checked;
  logic [5:0] lvl [8] = '{6'h05, 6'h0a, 6'h13, 6'h1c, 6'h21, 6'h2e, 6'h37, 6'h3f};
  logic [5:0] expc [8] = '{6'h00, 6'h00, 6'h08, 6'h10, 6'h18, 6'h20, 6'h28, 6'h30};

  aluc_ctrl i_aluc_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .mode_strap(mode_strap),
    .config_strap(config_strap), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .parallel_level_port(parallel_level_port), .interface_clock(interface_clock),
    .gain_strobe(gain_strobe), .tx_word_sync(tx_word_sync), .tx_nibble(tx_nibble),
    .filter_nibble(filter_nibble), .filter_valid(filter_valid),
    .filter_word_sync(filter_word_sync), .receive_amplifier(receive_amplifier),
    .converter_atten(converter_atten), .driver_atten(driver_atten),
    .driver_enable(driver_enable)
  );
  aluc_asic i_aluc_asic (
    .interface_clock(interface_clock), .gain_strobe(gain_strobe),
    .tx_word_sync(tx_word_sync), .tx_nibble(tx_nibble)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // link clock runs free, offset so edges never line up with the core
  initial begin
    interface_clock = 1'b0;
    #1.3;
    forever #6 interface_clock = ~interface_clock;
  end

  function automatic logic [6:0] split(input int code);
    int c;
    c = (code > 60) ? 60 : code;
    return {2'(c / 18), 2'((c % 18) / 6), 3'(c % 6)};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic amp(input int code);
    check({1'b0, receive_amplifier}, {1'b0, split(code)});
  endtask

  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // eight core cycles a half period, twice the shortest the sync allows
  task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] wd);
    logic [15:0] f;
    f = {rw, a, wd};
    rd = 8'h00;
    @(posedge core_clk) spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= f[i];
      repeat (8) @(posedge core_clk);
      if (i < 8) rd[i] = spi_sdo;
      if (i < 8) check({7'h0, spi_sdo_oe}, {7'h0, rw});
      spi_sclk <= 1'b1;
      repeat (8) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    repeat (30) @(posedge core_clk);
  endtask

  task automatic reset(input int n, input logic m);
    @(posedge core_clk);
    rst_n <= 1'b0;
    mode_strap <= m;
    repeat (n) @(posedge core_clk);
    amp(0);
    check({2'h0, driver_atten}, 8'h00);
    check({7'h0, driver_enable}, 8'h01);
    rst_n <= 1'b1;
    repeat (12) @(posedge core_clk);
  endtask

  task automatic wait_load(input int code);
    repeat (20) @(posedge core_clk);
    amp(code);
  endtask

  initial begin
    fails = 0;
    checked = 0;
    rst_n = 1'b0;
    mode_strap = 1'b0;
    config_strap = 1'b1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    parallel_level_port = 6'h00;
    reset(3, 1'b0);
    for (int i = 0; i < 8; i++) begin
      parallel_level_port <= lvl[i];
      repeat (8) @(posedge core_clk);
      amp(expc[i]);
    end
    spi(1'b1, ADDR_SRC, 8'h00);
    check(rd, 8'h22);
    spi(1'b0, ADDR_SRC, 8'h00);
    spi(1'b0, ADDR_RX, 8'h45);
    amp(5);
    spi(1'b0, ADDR_RX, 8'h0a);
    amp(5);
    spi(1'b1, ADDR_RX, 8'h00);
    check(rd, 8'h00);
    i_aluc_asic.load(6'h3f, 1'b1);
    wait_load(5);
    spi(1'b0, ADDR_TX, 8'h4f);
    check({2'h0, driver_atten}, 8'h0f);
    check({4'h0, converter_atten}, 8'h00);
    spi(1'b1, ADDR_TX, 8'h00);
    check(rd, 8'h4f);
    spi(1'b0, ADDR_OUT, 8'h01);
    check({4'h0, converter_atten}, 8'h0f);
    check({1'b0, driver_enable, driver_atten}, 8'h00);
    spi(1'b0, ADDR_TX, 8'h72);
    check({4'h0, converter_atten}, 8'h02);
    spi(1'b0, ADDR_TX, 8'h15);
    check({4'h0, converter_atten}, 8'h02);
    spi(1'b0, ADDR_OUT, 8'h00);
    check({2'h0, driver_atten}, 8'h27);
    spi(1'b1, 7'h03, 8'h00);
    check(rd, 8'h00);
    // receive already deselected, so the new code may settle first
    parallel_level_port <= 6'h0c;
    spi(1'b0, ADDR_SRC, 8'h40);
    check({2'h0, driver_atten}, 8'h0c);
    amp(5);
    parallel_level_port <= 6'h21;
    spi(1'b0, ADDR_SRC, 8'h60);
    check({2'h0, driver_atten}, 8'h21);
    amp(33);
    reset(10, 1'b1);
    spi(1'b1, ADDR_SRC, 8'h00);
    check(rd, 8'h04);
    i_aluc_asic.load(6'h14, 1'b1);
    wait_load(20);
    check({2'h0, filter_nibble}, 8'h2b);
    check({7'h0, filter_valid}, 8'h01);
    check({7'h0, filter_word_sync}, 8'h01);
    spi(1'b0, ADDR_SRC, 8'h0c);
    i_aluc_asic.load(6'h1e, 1'b0);
    wait_load(30);
    check({7'h0, filter_valid}, 8'h00);
    spi(1'b0, ADDR_CLK, 8'h02);
    i_aluc_asic.load(6'h07, 1'b0);
    wait_load(7);
    finish_test;
  end

  // the full sequence needs under ten thousand core cycles
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule
